// [logic/rtrc_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rtrc_consts.svh"

module rtrc_ctrl
  import rtrc_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cfg_wr,
  input wire logic [`RTRC_CFG_WIDTH-1:0] i_cfg_wdata,
  input wire logic [ADDR_W-1:0] i_rt_addr,
  input wire logic i_rt_addr_par,
  input wire logic i_auto_init_busy,
  input wire logic i_status_fail_clr,
  input wire logic i_pending_fail_clr,
  output logic [`RTRC_CFG_WIDTH-1:0] o_cfg_rdata,
  output logic o_rt_run,
  output logic o_soft_reset_start,
  output logic o_status_addr_par_fail,
  output logic o_pending_addr_par_fail,
  output logic o_soft_reset_misuse
);

  // ****************************************************************
  // reset release synchroniser
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_reg <= 1'h0;
      rst_sync_reg <= 1'h0;
    end else begin
      rst_meta_reg <= 1'h1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire rst_n;
  assign rst_n = rst_sync_reg;

  // ****************************************************************
  // address parity check
  // ****************************************************************
  logic addr_par_fail;

  rtrc_addr_parity #(
    .ADDR_W(ADDR_W)
  ) u_addr_parity (
    .i_addr(i_rt_addr),
    .i_addr_par(i_rt_addr_par),
    .o_par_fail(addr_par_fail)
  );

  // ****************************************************************
  // host write decode
  // ****************************************************************
  wire wr_run_enable;
  wire wr_soft_reset;
  wire [1:0] wr_spare;

  assign wr_run_enable = i_cfg_wdata[`RTRC_RUN_ENABLE_BIT];
  assign wr_soft_reset = i_cfg_wr & i_cfg_wdata[`RTRC_SOFT_RESET_BIT];
  assign wr_spare = i_cfg_wdata[`RTRC_SPARE_HI_BIT:`RTRC_SPARE_LO_BIT];

  // ****************************************************************
  // configuration bits
  // ****************************************************************
  logic run_enable_reg;
  logic run_enable_next;
  logic soft_reset_reg;
  logic soft_reset_next;
  logic [1:0] spare_reg;
  logic [1:0] spare_next;

  // run enable survives the software reset
  assign run_enable_next = i_cfg_wr ? wr_run_enable : run_enable_reg;

  // self clearing: high for one cycle only
  assign soft_reset_next = wr_soft_reset & ~soft_reset_reg;

  // spare bits store writes, drive nothing, cleared by soft reset
  assign spare_next = soft_reset_reg ? `RTRC_SPARE_RST : (i_cfg_wr ? wr_spare : spare_reg);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_enable_reg <= `RTRC_RUN_ENABLE_RST;
      soft_reset_reg <= `RTRC_SOFT_RESET_RST;
      spare_reg <= `RTRC_SPARE_RST;
    end else begin
      run_enable_reg <= run_enable_next;
      soft_reset_reg <= soft_reset_next;
      spare_reg <= spare_next;
    end
  end

  // ****************************************************************
  // terminal operating state
  // ****************************************************************
  rtrc_state_t state_reg;
  rtrc_state_t state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RTRC_STOPPED: begin
        if (run_enable_reg && addr_par_fail) begin
          state_next = RTRC_PAR_HALT;
        end else if (run_enable_reg) begin
          state_next = RTRC_RUNNING;
        end
      end
      RTRC_RUNNING: begin
        if (!run_enable_reg) begin
          state_next = RTRC_STOPPED;
        end else if (addr_par_fail) begin
          state_next = RTRC_PAR_HALT;
        end
      end
      RTRC_PAR_HALT: begin
        if (!run_enable_reg) begin
          state_next = RTRC_STOPPED;
        end
      end
      default: begin
        state_next = RTRC_STOPPED;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= RTRC_STOPPED;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // address parity fail flags
  // ****************************************************************
  wire par_fail_event;
  logic status_fail_reg;
  logic status_fail_next;
  logic pending_fail_reg;
  logic pending_fail_next;

  // entry into halt; a set beats a clear in the same cycle
  assign par_fail_event = (state_next == RTRC_PAR_HALT) && (state_reg != RTRC_PAR_HALT);
  assign status_fail_next = par_fail_event | (status_fail_reg & ~i_status_fail_clr);
  assign pending_fail_next = par_fail_event | (pending_fail_reg & ~i_pending_fail_clr);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_fail_reg <= 1'h0;
      pending_fail_reg <= 1'h0;
    end else begin
      status_fail_reg <= status_fail_next;
      pending_fail_reg <= pending_fail_next;
    end
  end

  // ****************************************************************
  // misuse flag: soft reset during self-initialisation
  // ****************************************************************
  logic misuse_reg;
  logic misuse_next;

  // sticky until reset; the reset still launches
  assign misuse_next = misuse_reg | (wr_soft_reset & i_auto_init_busy);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      misuse_reg <= 1'h0;
    end else begin
      misuse_reg <= misuse_next;
    end
  end

  // ****************************************************************
  // outputs, all straight from flops
  // ****************************************************************
  logic rt_run_reg;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rt_run_reg <= 1'h0;
    end else begin
      rt_run_reg <= (state_next == RTRC_RUNNING);
    end
  end

  assign o_rt_run = rt_run_reg;
  assign o_soft_reset_start = soft_reset_reg;
  assign o_status_addr_par_fail = status_fail_reg;
  assign o_pending_addr_par_fail = pending_fail_reg;
  assign o_soft_reset_misuse = misuse_reg;

  // ****************************************************************
  // readback word assembly
  // ****************************************************************
  wire [`RTRC_CFG_WIDTH-1:0] rdata_word;

  // unused positions read as zero
  genvar b;
  generate
    for (b = 0; b < `RTRC_CFG_WIDTH; b = b + 1) begin : g_rdata
      if (b == `RTRC_RUN_ENABLE_BIT) begin : g_run
        assign rdata_word[b] = run_enable_reg;
      end else if (b == `RTRC_SOFT_RESET_BIT) begin : g_soft
        assign rdata_word[b] = soft_reset_reg;
      end else if (b == `RTRC_SPARE_HI_BIT) begin : g_spare_hi
        assign rdata_word[b] = spare_reg[1];
      end else if (b == `RTRC_SPARE_LO_BIT) begin : g_spare_lo
        assign rdata_word[b] = spare_reg[0];
      end else begin : g_zero
        assign rdata_word[b] = 1'h0;
      end
    end
  endgenerate

  assign o_cfg_rdata = rdata_word;

endmodule : rtrc_ctrl

`default_nettype wire

// [logic/rtrc_consts.svh]
`ifndef RTRC_CONSTS_SVH
`define RTRC_CONSTS_SVH

// ****************************************************************
// configuration word bit positions
// ****************************************************************
`define RTRC_RUN_ENABLE_BIT 8
`define RTRC_SOFT_RESET_BIT 7
`define RTRC_SPARE_HI_BIT 6
`define RTRC_SPARE_LO_BIT 5
`define RTRC_CFG_WIDTH 16

// ****************************************************************
// reset values
// ****************************************************************
`define RTRC_RUN_ENABLE_RST 1'h0
`define RTRC_SOFT_RESET_RST 1'h0
`define RTRC_SPARE_RST 2'h0

// ****************************************************************
// timing counts
// ****************************************************************
`define RTRC_SOFT_RESET_CYCLES 1

`endif

// [logic/rtrc_pkg.sv]
package rtrc_pkg;

  // ****************************************************************
  // terminal operating state, gray coded along stopped-run-halted
  // ****************************************************************
  typedef enum logic [1:0] {
    RTRC_STOPPED = 2'h0,
    RTRC_RUNNING = 2'h1,
    RTRC_PAR_HALT = 2'h3
  } rtrc_state_t;

endpackage : rtrc_pkg

// [logic/rtrc_addr_parity.sv]
`timescale 1ns/100ps
`default_nettype none

module rtrc_addr_parity #(
  parameter int ADDR_W = 5
) (
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_addr_par,
  output logic o_par_fail
);

  // ****************************************************************
  // odd parity over address plus parity pin
  // ****************************************************************
  wire [ADDR_W:0] chain;

  assign chain[0] = i_addr_par;

  genvar g;
  generate
    for (g = 0; g < ADDR_W; g = g + 1) begin : g_xor
      assign chain[g+1] = chain[g] ^ i_addr[g];
    end
  endgenerate

  // even count of ones means a bad address
  assign o_par_fail = ~chain[ADDR_W];

endmodule : rtrc_addr_parity

`default_nettype wire

// [sim/rtrc_ctrl_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rtrc_consts.svh"

module rtrc_ctrl_asserts #(
  parameter int ADDR_W = 5
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cfg_wr,
  input wire logic [`RTRC_CFG_WIDTH-1:0] i_cfg_wdata,
  input wire logic [ADDR_W-1:0] i_rt_addr,
  input wire logic i_rt_addr_par,
  input wire logic [`RTRC_CFG_WIDTH-1:0] o_cfg_rdata,
  input wire logic o_rt_run,
  input wire logic o_soft_reset_start,
  input wire logic o_status_addr_par_fail,
  input wire logic o_pending_addr_par_fail
);
  // odd parity over address and parity pin is good
  wire logic par_ok = ^{i_rt_addr, i_rt_addr_par};
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  chk_run_start: assert property ($rose(o_cfg_rdata[8]) && par_ok |=> o_rt_run)
    else $error("terminal did not start");
  chk_run_stop: assert property (!o_cfg_rdata[8] |=> !o_rt_run)
    else $error("terminal runs without enable");
  chk_par_block: assert property (!par_ok |=> !o_rt_run)
    else $error("terminal runs with bad parity");
  chk_flag_set: assert property ($rose(o_cfg_rdata[8]) && !par_ok |=>
    o_status_addr_par_fail && o_pending_addr_par_fail)
    else $error("parity fail flags not set");
  chk_soft_pulse: assert property (i_cfg_wr && i_cfg_wdata[7] && !o_soft_reset_start |=>
    o_soft_reset_start && o_cfg_rdata[7])
    else $error("soft reset not launched");
  chk_soft_clear: assert property (o_soft_reset_start |=> !o_soft_reset_start && !o_cfg_rdata[7])
    else $error("soft reset bit did not clear");
  chk_spare_zero: assert property (o_soft_reset_start |=> o_cfg_rdata[6:5] == 2'h0)
    else $error("spare bits survive soft reset");
  chk_write_echo: assert property (i_cfg_wr |=> o_cfg_rdata[8] == $past(i_cfg_wdata[8]))
    else $error("run enable readback wrong");
endmodule : rtrc_ctrl_asserts

`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, par = 1'b1, busy = 1'b0, sclr = 1'b0, pclr = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic [4:0] addr = 5'h03;
  logic [15:0] rd;
  logic run, srs, fs, fp, mis;
  int n_mismatch = 0;
  int checks_done = 0;
  wire logic [20:0] obs = {rd, run, srs, fs, fp, mis};
  rtrc_ctrl u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_cfg_wr(wr), .i_cfg_wdata(wd), .i_rt_addr(addr),
    .i_rt_addr_par(par), .i_auto_init_busy(busy), .i_status_fail_clr(sclr), .i_pending_fail_clr(pclr),
    .o_cfg_rdata(rd), .o_rt_run(run), .o_soft_reset_start(srs), .o_status_addr_par_fail(fs),
    .o_pending_addr_par_fail(fp), .o_soft_reset_misuse(mis));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic conclude;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [20:0] exp);
    checks_done++;
    if (obs !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t outputs %h expected %h", $time, obs, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wr_cfg(input logic [15:0] d);
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_cfg
  task automatic t_run;
    wr_cfg(16'h0100);
    chk({16'h0100, 5'b00000});
    cyc(1);
    chk({16'h0100, 5'b10000});
    wr_cfg(16'h0000);
    cyc(1);
    chk(21'h0);
  endtask : t_run
  task automatic t_parity;
    par = 1'b0;
    wr_cfg(16'h0100);
    cyc(1);
    chk({16'h0100, 5'b00110});
    sclr = 1'b1;
    pclr = 1'b1;
    par = 1'b1;
    cyc(1);
    sclr = 1'b0;
    pclr = 1'b0;
    cyc(2);
    chk({16'h0100, 5'b00000});
    wr_cfg(16'h0000);
    cyc(1);
  endtask : t_parity
  task automatic t_soft;
    wr_cfg(16'h0100);
    cyc(1);
    wr_cfg(16'h01E0);
    chk({16'h01E0, 5'b11000});
    cyc(1);
    chk({16'h0100, 5'b10000});
    busy = 1'b1;
    wr_cfg(16'hFF7F);
    busy = 1'b0;
    chk({16'h0160, 5'b10000});
    cyc(2);
    chk({16'h0160, 5'b10000});
  endtask : t_soft
  task automatic t_mreset;
    rst_n = 1'b0;
    cyc(1);
    chk(21'h0);
    rst_n = 1'b1;
    cyc(6);
    chk(21'h0);
  endtask : t_mreset
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    cyc(4);
    chk(21'h0);
    t_run();
    t_parity();
    t_soft();
    t_mreset();
    conclude();
  end
  initial begin
    #5000;
    n_mismatch++;
    conclude();
  end
endmodule : testbench

bind rtrc_ctrl rtrc_ctrl_asserts #(.ADDR_W(ADDR_W)) u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_cfg_wr(i_cfg_wr), .i_cfg_wdata(i_cfg_wdata), .i_rt_addr(i_rt_addr), .i_rt_addr_par(i_rt_addr_par),
  .o_cfg_rdata(o_cfg_rdata), .o_rt_run(o_rt_run), .o_soft_reset_start(o_soft_reset_start),
  .o_status_addr_par_fail(o_status_addr_par_fail), .o_pending_addr_par_fail(o_pending_addr_par_fail));

`default_nettype wire
